// ==== hw/fpwm_pkg.sv ====
package fpwm_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BHVR1 = 8'h36; // Channel-1 behaviour
  localparam logic [7:0] IDX_CFG1 = 8'h40;  // Global configuration 1
  localparam logic [7:0] IDX_SPAN1 = 8'h5F; // Remote 1 span/rate
  localparam logic [7:0] IDX_SPAN2 = 8'h60; // Local span/rate
  localparam logic [7:0] IDX_SPAN3 = 8'h61; // Remote 2 span/rate
  localparam int ADDR_W = 12;
  localparam logic [11:0] A_BHVR1 = {2'h0, IDX_BHVR1, 2'h0};
  localparam logic [11:0] A_CFG1 = {2'h0, IDX_CFG1, 2'h0};
  localparam logic [11:0] A_SPAN1 = {2'h0, IDX_SPAN1, 2'h0};
  localparam logic [11:0] A_SPAN2 = {2'h0, IDX_SPAN2, 2'h0};
  localparam logic [11:0] A_SPAN3 = {2'h0, IDX_SPAN3, 2'h0};

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] SPAN_RST = 8'hC4;
  localparam logic [7:0] BHVR_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam int LOCK_BIT = 1;  // Config 1: lock
  localparam int SUBST_BIT = 4; // Behaviour: substitute mode
  localparam int ALT_BIT = 3;   // Behaviour: alternative set
  localparam int BAND_BIT = 3;  // Span/rate: high-frequency mode
  localparam int RATE_LSB = 0;  // Span/rate: low rate code [2:0]
  localparam int SPAN_LSB = 4;  // Span/rate: span code [7:4]

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125_000_000;
  // Base tick: 176.4 Hz times 256 duty steps, in milli-hertz
  localparam longint LF_BASE_MHZ = 176_400;
  localparam longint LF_TICK_CYC = (CLK_HZ * 1000) / (LF_BASE_MHZ * 256);
  localparam longint HF_LOW_RATE_CODE_HZ = 22_000;
  localparam longint HF_STEP_CYC = CLK_HZ / (HF_LOW_RATE_CODE_HZ * 256);
  localparam logic [11:0] LF_TICK_LIM = 12'(LF_TICK_CYC - 1);
  localparam logic [11:0] HF_STEP_LIM = 12'(HF_STEP_CYC - 1);

  // Base ticks per duty step for each low rate code
  function automatic logic [4:0] rate_div(input logic [2:0] code);
    case (code)
      3'h0: rate_div = 5'h10; // 11.0 Hz
      3'h1: rate_div = 5'h0C; // 14.7 Hz
      3'h2: rate_div = 5'h08; // 22.1 Hz
      3'h3: rate_div = 5'h06; // 29.4 Hz
      3'h4: rate_div = 5'h05; // 35.3 Hz
      3'h5: rate_div = 5'h04; // 44.1 Hz
      3'h6: rate_div = 5'h03; // 58.8 Hz
      default: rate_div = 5'h02; // 88.2 Hz
    endcase
  endfunction

  // 256 divided by the span in degrees, rounded
  function automatic logic [7:0] span_recip(input logic [3:0] code);
    case (code)
      4'h0: span_recip = 8'h80; // 2
      4'h1: span_recip = 8'h66; // 2.5
      4'h2: span_recip = 8'h4D; // 3.33
      4'h3: span_recip = 8'h40; // 4
      4'h4: span_recip = 8'h33; // 5
      4'h5: span_recip = 8'h26; // 6.67
      4'h6: span_recip = 8'h20; // 8
      4'h7: span_recip = 8'h1A; // 10
      4'h8: span_recip = 8'h13; // 13.33
      4'h9: span_recip = 8'h10; // 16
      4'hA: span_recip = 8'h0D; // 20
      4'hB: span_recip = 8'h0A; // 26.67
      4'hC: span_recip = 8'h08; // 32
      4'hD: span_recip = 8'h06; // 40
      4'hE: span_recip = 8'h05; // 53.33
      default: span_recip = 8'h03; // 80
    endcase
  endfunction

endpackage

// ==== hw/fpwm_chan.sv ====
`timescale 1ns/1ps
`default_nettype none

module fpwm_chan
  import fpwm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Channel setup and sensor
  input wire logic [7:0] cfg,
  input wire logic [7:0] temp,
  input wire logic [7:0] tmin,
  input wire logic [7:0] duty_min,
  // Drive
  output logic [7:0] duty_r,
  output logic pwm_r
);

  // ----------------------------------------------------------------
  // Step timing
  // ----------------------------------------------------------------
  logic band;          // High-frequency mode
  logic [11:0] pre_lim; // Prescaler limit
  logic [4:0] sub_lim;  // Ticks per step minus one
  logic [11:0] pre_r;
  logic [4:0] sub_r;
  logic [7:0] step_r;
  logic pre_end;
  logic sub_end;

  assign band = cfg[BAND_BIT];
  assign pre_lim = band ? HF_STEP_LIM : LF_TICK_LIM;
  // Rate code only counts in low-frequency mode
  assign sub_lim = band ? 5'h00 :
    rate_div(cfg[RATE_LSB +: 3]) - 5'h01;
  // Compare with >= so a smaller limit after a mode change recovers
  assign pre_end = pre_r >= pre_lim;
  assign sub_end = sub_r >= sub_lim;

  // Prescaler, divider and duty step counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= 12'h000;
      sub_r <= 5'h00;
      step_r <= 8'h00;
    end else begin
      pre_r <= pre_end ? 12'h000 : pre_r + 12'h001;
      if (pre_end) begin
        sub_r <= sub_end ? 5'h00 : sub_r + 5'h01;
      end
      if (pre_end && sub_end) begin
        step_r <= step_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Duty ramp over the span
  // ----------------------------------------------------------------
  logic [7:0] diff;   // Degrees above start
  logic [15:0] frac;  // Fraction of span, 8 fraction bits
  logic [7:0] head;   // Room above minimum
  logic [7:0] span_end; // Whole degrees where full duty starts
  logic [7:0] frac_lo;  // Fraction held below one
  logic [15:0] ramp;
  logic full;
  logic [7:0] duty_nxt;
  logic pwm_nxt;

  // Span rounded up to whole degrees
  function automatic logic [7:0] span_deg(input logic [3:0] code);
    case (code)
      4'h0: span_deg = 8'h02; // 2
      4'h1: span_deg = 8'h03; // 2.5
      4'h2: span_deg = 8'h04; // 3.33
      4'h3: span_deg = 8'h04; // 4
      4'h4: span_deg = 8'h05; // 5
      4'h5: span_deg = 8'h07; // 6.67
      4'h6: span_deg = 8'h08; // 8
      4'h7: span_deg = 8'h0A; // 10
      4'h8: span_deg = 8'h0E; // 13.33
      4'h9: span_deg = 8'h10; // 16
      4'hA: span_deg = 8'h14; // 20
      4'hB: span_deg = 8'h1B; // 26.67
      4'hC: span_deg = 8'h20; // 32
      4'hD: span_deg = 8'h28; // 40
      4'hE: span_deg = 8'h36; // 53.33
      default: span_deg = 8'h50; // 80
    endcase
  endfunction

  assign diff = (temp > tmin) ? temp - tmin : 8'h00;
  assign frac = diff * span_recip(cfg[SPAN_LSB +: 4]);
  // The reciprocal is rounded down for some spans, so the product
  // alone would miss full duty at the far end; compare whole degrees
  assign span_end = span_deg(cfg[SPAN_LSB +: 4]);
  assign full = diff >= span_end;
  // A rounded-up reciprocal may pass one just below the span end
  assign frac_lo = (frac[15:8] != 8'h00) ? 8'hFF : frac[7:0];
  assign head = 8'hFF - duty_min;
  assign ramp = head * frac_lo;
  // Minimum at start, full duty at start plus span
  assign duty_nxt = full ? 8'hFF : duty_min + ramp[15:8];
  // Full scale duty holds the output high all period
  assign pwm_nxt = (duty_r == 8'hFF) || (step_r < duty_r);

  // Duty and output flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_r <= 8'h00;
      pwm_r <= 1'b0;
    end else begin
      duty_r <= duty_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hf_ignores_code: assert property (band |-> sub_lim == 5'h00)
    else $error("rate code used in high-frequency mode");
  a_lf_divider: assert property (
    !band && cfg[2:0] == 3'h4 |-> sub_lim == 5'h04)
    else $error("default rate divider wrong");
  a_band_prescale: assert property (
    band |-> pre_lim == 12'(HF_STEP_CYC - 1))
    else $error("high-frequency prescale wrong");
  a_span_full: assert property (
    full ##1 $stable(cfg) |-> duty_r == 8'hFF)
    else $error("duty not full beyond span");
  a_duty_floor: assert property (
    temp <= tmin |=> duty_r == $past(duty_min))
    else $error("duty not at minimum below start");

endmodule

`default_nettype wire

// ==== hw/fpwm_top.sv ====
// Functional notes
// - Three span/rate registers, one per channel
// - Each register resets to its default
// - Lock bit makes them read-only
// - Bits 2:0 select low-frequency rate
// - Rate code ignored in high-frequency mode
// - Bit 3 selects high or low band
// - Bits 7:4 select temperature span
// - Substitute mode forces channel 1 alternative
`timescale 1ns/1ps
`default_nettype none

module fpwm_top
  import fpwm_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sensor readings, whole degrees
  input wire logic [7:0] temp_remote1,
  input wire logic [7:0] temp_local,
  input wire logic [7:0] temp_remote2,
  // Per-channel start temperature and minimum duty, ch1 low
  input wire logic [23:0] tmin_all,
  input wire logic [23:0] duty_min_all,
  // Fan side
  output logic [2:0] fan_drive_output,
  output logic [2:0] rate_band_select,
  output logic alt_behaviour_ch1,
  output logic cfg_locked
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] span_r [3]; // Span/rate, one per channel
  logic [7:0] bhvr_r;     // Channel-1 behaviour
  logic [7:0] cfg1_r;     // Global configuration 1
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic alt_r;
  logic wrote_r;          // Any span write taken since reset

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_span1 = paddr == A_SPAN1;
  wire hit_span2 = paddr == A_SPAN2;
  wire hit_span3 = paddr == A_SPAN3;
  wire hit_bhvr = paddr == A_BHVR1;
  wire hit_cfg1 = paddr == A_CFG1;
  wire hit_span = hit_span1 | hit_span2 | hit_span3;
  wire hit_any = hit_span | hit_bhvr | hit_cfg1;

  // Lock state; once set it holds until reset
  wire locked = cfg1_r[LOCK_BIT];

  // Setup cycle and completing access
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_r;
  wire wr_acc = access & pwrite;

  // Per-register write enables
  wire wr_span1 = wr_acc & hit_span1 & ~locked;
  wire wr_span2 = wr_acc & hit_span2 & ~locked;
  wire wr_span3 = wr_acc & hit_span3 & ~locked;
  wire wr_bhvr = wr_acc & hit_bhvr & ~locked;
  wire wr_cfg1 = wr_acc & hit_cfg1;
  wire [2:0] wr_span = {wr_span3, wr_span2, wr_span1};

  // Lock bit is sticky so software cannot unlock itself
  wire [7:0] cfg1_nxt = pwdata[7:0] | (cfg1_r & (8'h01 << LOCK_BIT));

  // ----------------------------------------------------------------
  // Read mux; unmapped words read as zero
  // ----------------------------------------------------------------
  wire [7:0] rd_byte =
    hit_span1 ? span_r[0] :
    hit_span2 ? span_r[1] :
    hit_span3 ? span_r[2] :
    hit_bhvr ? bhvr_r :
    hit_cfg1 ? cfg1_r : 8'h00;
  wire [31:0] rdata_w = {24'h000000, rd_byte};

  // ----------------------------------------------------------------
  // APB handshake: one wait-free access phase per transfer
  // ----------------------------------------------------------------
  // Ready and data set up in the setup cycle so they come from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      // Unmapped addresses answer with an error
      pslverr_r <= setup & ~hit_any;
      if (setup) begin
        // Read data only for reads; writes return zero
        prdata_r <= pwrite ? 32'h00000000 : rdata_w;
      end
    end
  end

  // ----------------------------------------------------------------
  // Span/rate registers
  // ----------------------------------------------------------------
  // Writes while locked are dropped with no error, as software
  // expects a silent no-effect write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        span_r[i] <= SPAN_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_span[i]) begin
          span_r[i] <= pwdata[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Behaviour and configuration registers
  // ----------------------------------------------------------------
  // Host keeps behaviour bits zero while substituting; not enforced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bhvr_r <= BHVR_RST;
      cfg1_r <= CFG1_RST;
    end else begin
      if (wr_bhvr) begin
        bhvr_r <= pwdata[7:0];
      end
      if (wr_cfg1) begin
        cfg1_r <= cfg1_nxt;
      end
    end
  end

  // Substitute mode forces the alternative set on channel 1
  wire alt_nxt = bhvr_r[ALT_BIT] | bhvr_r[SUBST_BIT];

  // Status flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alt_r <= 1'b0;
      wrote_r <= 1'b0;
    end else begin
      alt_r <= alt_nxt;
      wrote_r <= wrote_r | (|wr_span);
    end
  end

  // ----------------------------------------------------------------
  // Channels: sensor pairing remote 1, local, remote 2
  // ----------------------------------------------------------------
  logic [7:0] temp_w [3];
  logic [7:0] duty_w [3];
  logic [2:0] pwm_w;

  assign temp_w[0] = temp_remote1;
  assign temp_w[1] = temp_local;
  assign temp_w[2] = temp_remote2;

  for (genvar g = 0; g < 3; g++) begin : g_chan
    fpwm_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(span_r[g]),
      .temp(temp_w[g]),
      .tmin(tmin_all[8*g +: 8]),
      .duty_min(duty_min_all[8*g +: 8]),
      .duty_r(duty_w[g]),
      .pwm_r(pwm_w[g])
    );
  end

  // ----------------------------------------------------------------
  // Outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign fan_drive_output = pwm_w;
  assign rate_band_select = {span_r[2][BAND_BIT], span_r[1][BAND_BIT],
    span_r[0][BAND_BIT]};
  assign alt_behaviour_ch1 = alt_r;
  assign cfg_locked = cfg1_r[LOCK_BIT];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Locked write to a span register
  sequence s_locked_span_wr;
    locked && access && pwrite && hit_span;
  endsequence

  // Unlocked write to channel 1
  sequence s_open_span1_wr;
    !locked && access && pwrite && hit_span1;
  endsequence

  // Unlocked write to channel 3
  sequence s_open_span3_wr;
    !locked && access && pwrite && hit_span3;
  endsequence

  // Read of channel 2 set up
  sequence s_span2_rd_setup;
    setup && !pwrite && hit_span2;
  endsequence

  // Write that sets the lock bit
  sequence s_lock_wr;
    access && pwrite && hit_cfg1 && pwdata[LOCK_BIT];
  endsequence

  // Locked write to the behaviour register
  sequence s_locked_bhvr_wr;
    locked && access && pwrite && hit_bhvr;
  endsequence

  // Ready rises once, for the single access cycle
  a_apb_ready: assert property (
    setup |=> pready_r ##1 !pready_r)
    else $error("ready not one cycle after setup");
  // No ready without a setup the cycle before
  a_ready_cause: assert property (
    !setup |=> !pready_r)
    else $error("ready without setup");
  // Error only alongside ready
  a_err_ready: assert property (pslverr_r |-> pready_r)
    else $error("error without ready");
  // Unmapped or misaligned words answer with an error and zero
  a_unmapped_err: assert property (
    setup && !hit_any |=> pslverr_r && prdata_r == 32'h00000000)
    else $error("unmapped access not flagged");
  // Mapped words never answer with an error
  a_mapped_ok: assert property (setup && hit_any |=> !pslverr_r)
    else $error("mapped access flagged");
  // Writes return zero read data
  a_write_rdata: assert property (
    setup && pwrite |=> prdata_r == 32'h00000000)
    else $error("write returned data");
  // Open write lands in channel 1
  a_span_write: assert property (
    s_open_span1_wr |=> span_r[0] == $past(pwdata[7:0]))
    else $error("span write not stored");
  // Open write lands in channel 3
  a_span3_write: assert property (
    s_open_span3_wr |=> span_r[2] == $past(pwdata[7:0]))
    else $error("channel 3 write not stored");
  // Read data taken from the addressed register
  a_span_read: assert property (
    s_span2_rd_setup |=> prdata_r == {24'h000000, span_r[1]})
    else $error("span read data wrong");
  // Untouched channel 1 and 3 span registers keep their default
  a_span_reset: assert property (
    !wrote_r |-> span_r[0] == SPAN_RST && span_r[2] == SPAN_RST)
    else $error("span not at default");
  // Locked writes leave every span register alone
  a_lock_ignores: assert property (
    s_locked_span_wr |=> $stable(span_r[0]) && $stable(span_r[1])
      && $stable(span_r[2]))
    else $error("locked span register changed");
  // Lock write shows on the status output
  a_lock_set: assert property (
    s_lock_wr |=> cfg_locked)
    else $error("lock not set by write");
  // Lock holds until reset
  a_lock_sticky: assert property (
    locked |=> locked)
    else $error("lock bit cleared");
  // Behaviour register is guarded by the lock too
  a_bhvr_lock: assert property (
    s_locked_bhvr_wr |=> $stable(bhvr_r))
    else $error("locked behaviour register changed");
  // Substitute mode forces the alternative set
  a_subst_alt: assert property (
    bhvr_r[SUBST_BIT] |=> alt_behaviour_ch1)
    else $error("substitute mode not applied");
  // Neither bit set leaves the default set
  a_alt_off: assert property (
    !bhvr_r[ALT_BIT] && !bhvr_r[SUBST_BIT] |=> !alt_behaviour_ch1)
    else $error("alternative set without cause");
  // Band output follows the register bit
  a_band_out: assert property (
    span_r[1][BAND_BIT] |-> rate_band_select[1])
    else $error("band select not shown");

endmodule

`default_nettype wire

// ==== verif/fpwm_fan_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Fan side: watches each drive line, measures pulse timing
// ------------------------------------------------------------
module fpwm_fan_model (
  // Clock
  input wire logic clk,
  // Drive lines, bit 0 is channel 1
  input wire logic [2:0] pwm
);
  int period [3]; // Cycles between rising edges
  int high_t [3]; // Cycles of the last whole high pulse
  int lows [3];   // Running count of low cycles
  int cnt [3];    // Cycles since last rise
  int hrun [3];   // Length of current high run
  logic [2:0] prev = 3'h0;

  initial begin
    for (int c = 0; c < 3; c++) begin
      period[c] = 0;
      high_t[c] = 0;
      lows[c] = 0;
      cnt[c] = 0;
      hrun[c] = 0;
    end
  end

  // Sample away from the launching edge so flop updates have landed
  always @(negedge clk) begin
    for (int c = 0; c < 3; c++) begin
      // A fan has no say in the drive; it only loads the line
      if (pwm[c] && !prev[c]) begin
        period[c] = cnt[c];
        cnt[c] = 0;
      end
      if (!pwm[c] && prev[c]) begin
        high_t[c] = hrun[c];
      end
      cnt[c]++;
      if (pwm[c]) begin
        hrun[c]++;
      end else begin
        hrun[c] = 0;
        lows[c]++;
      end
    end
    prev = pwm;
  end
endmodule

`default_nettype wire

// ==== verif/fpwm_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("FAIL %0t mismatch got %0h exp %0h", $time, g, e); end end

module fpwm_top_bench;
  import fpwm_pkg::*;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] t_r1 = 8'h00;
  logic [7:0] t_lo = 8'h00;
  logic [7:0] t_r2 = 8'h00;
  logic [23:0] tmin_all = 24'h0;
  logic [23:0] duty_min_all = 24'h404040; // Same floor on all three
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [2:0] fan_out;
  wire [2:0] band;
  wire alt;
  wire locked_o;
  int num_errors = 0;
  int cmp_count = 0;
  int mdl [logic [11:0]]; // Register image kept by the bench
  bit locked = 1'b0;
  logic [11:0] sa [3];
  logic [7:0] tv;
  int lw [3];
  int gap;
  logic [7:0] sv;

  always #4 pclk = ~pclk;

  fpwm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_remote1(t_r1), .temp_local(t_lo), .temp_remote2(t_r2),
    .tmin_all(tmin_all), .duty_min_all(duty_min_all),
    .fan_drive_output(fan_out), .rate_band_select(band),
    .alt_behaviour_ch1(alt), .cfg_locked(locked_o));

  fpwm_fan_model u_fan (.clk(pclk), .pwm(fan_out));

  // ------------------------------------------------------------
  // Closing report
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One APB transfer, checked against the register image
  task automatic apb(input bit wr, input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    int n;
    bit hit;
    hit = mdl.exists(a);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'($urandom), d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Bounded wait; ready and the answer are taken at one rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(err, logic'(!hit))
    if (!wr && hit) `CHK(rd, 32'(mdl[a]))
    if (!wr && !hit) `CHK(rd, 32'h0)
    // Lock is sticky and guards every register but its own
    if (wr && hit) begin
      if (a == A_CFG1) begin
        mdl[a] = d | (locked ? 2 : 0);
        locked |= d[LOCK_BIT];
      end else if (!locked) begin
        mdl[a] = d;
      end
    end
  endtask

  // Program all channels, place each sensor at or above its start point
  task automatic fan_round(input logic [7:0] c1, c2, c3, o1, o2, o3);
    int l0 [3];
    apb(1'b1, A_SPAN1, c1);
    apb(1'b1, A_SPAN2, c2);
    apb(1'b1, A_SPAN3, c3);
    t_r1 <= tv + o1;
    t_lo <= tv + o2;
    t_r2 <= tv + o3;
    repeat (2 * 5632 + 200) @(posedge pclk);
    for (int c = 0; c < 3; c++) l0[c] = u_fan.lows[c];
    repeat (5700) @(posedge pclk);
    for (int c = 0; c < 3; c++) lw[c] = u_fan.lows[c] - l0[c];
  endtask

  // Watchdog against a hang anywhere
  initial begin
    repeat (90000) @(posedge pclk);
    num_errors++;
    stop_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h95B2));
    sa = '{A_SPAN1, A_SPAN2, A_SPAN3};
    mdl[A_SPAN1] = 8'hC4;
    mdl[A_SPAN2] = 8'hC4;
    mdl[A_SPAN3] = 8'hC4;
    mdl[A_BHVR1] = 8'h00;
    mdl[A_CFG1] = 8'h00;
    tv = 8'($urandom_range(96, 16));
    tmin_all <= {3{tv}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Defaults, then a hole and a misaligned word
    foreach (mdl[a]) apb(1'b0, a, 8'h00);
    apb(1'b0, 12'h004, 8'h00);
    apb(1'b1, A_SPAN1 + 12'h001, 8'h3C);
    apb(1'b0, A_SPAN1, 8'h00);
    `CHK(band, 3'b000)
    // Every span and rate code written and read back
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, sa[i % 3], {4'(i), 1'($urandom), 3'(i)});
      apb(1'b0, sa[i % 3], 8'h00);
    end
    // High band, rate codes differ: periods must not
    fan_round(8'h08, 8'h0F, {5'h01, 3'($urandom)}, 8'h00, 8'h01, 8'h02);
    `CHK(band, 3'b111)
    `CHK(u_fan.period[0], 5632)
    `CHK(u_fan.period[1], 5632)
    `CHK(u_fan.high_t[0], 1408)
    `CHK(u_fan.high_t[1] inside {[3476:3520]}, 1'b1)
    `CHK(lw[2], 0)
    // Widest span: full only at the far end
    fan_round(8'hF8, 8'hF8, 8'hF8, 8'd80, 8'd79, 8'h00);
    `CHK(lw[0], 0)
    `CHK(lw[1] > 0, 1'b1)
    `CHK(u_fan.high_t[2], 1408)
    apb(1'b1, A_SPAN1, 8'hC4);
    repeat (2) @(posedge pclk);
    `CHK(band, 3'b110)
    // Low band, fastest code: a duty step every two base ticks
    apb(1'b1, A_SPAN1, 8'hC7);
    for (int s = 0; s < 3; s++) begin
      sv = i_dut.g_chan[0].u_chan.step_r;
      gap = 0;
      while (i_dut.g_chan[0].u_chan.step_r == sv && gap < 9000) begin
        @(posedge pclk);
        gap++;
      end
    end
    `CHK(gap, 2 * LF_TICK_CYC)
    if (gap >= 9000) stop_test();
    // Behaviour bits 7:5 stay zero while substituting
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, A_BHVR1, 8'(k << 3));
      repeat (3) @(posedge pclk);
      `CHK(alt, logic'(k != 0))
    end
    // Lock, then try to change everything
    apb(1'b1, A_CFG1, 8'h02);
    apb(1'b1, A_CFG1, 8'h00);
    apb(1'b0, A_CFG1, 8'h00);
    `CHK(locked_o, 1'b1)
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, sa[i], 8'h3B);
      apb(1'b0, sa[i], 8'h00);
    end
    apb(1'b1, A_BHVR1, 8'h00);
    repeat (3) @(posedge pclk);
    `CHK(alt, 1'b1)
    `CHK(band, 3'b110)
    stop_test();
  end
endmodule

`default_nettype wire
